// file: fcs_blk_mem.sv
// Small block address list memory with registered read data
module fcs_blk_mem
	import fcs_pkg::*;
(
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [BLK_AW-1:0] wr_addr_in,
	input wire logic [ADDR_W-1:0] wr_data_in,
	input wire logic [BLK_AW-1:0] rd_addr_in,
	output logic [ADDR_W-1:0] rd_data_out
);
	logic [ADDR_W-1:0] mem [BLK_DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule : fcs_blk_mem

// file: fcs_flash_model.sv
// Behavioural flash device seen by the host
module fcs_flash_model
	import fcs_pkg::*;
#(
	parameter int BUSY_READS = 3,
	parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3C // Arbitrary value
)
(
	input wire logic vpp_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic [7:0] cmd, pend, pd, val, last;
	logic [ADDR_W-1:0] la;
	logic prog, tog, wr_act;
	// A write lasts while select and strobe are both low, whichever moves first
	assign wr_act = !ce_n_in && !we_n_in;
	int busy;
	// Blocks taken as 4 KB granules; coarser blocks are not modelled
	task automatic erase(input logic [ADDR_W-1:0] lo, input int n);
		for (int i = 0; i < n; i++) mem[lo+i] = 8'hFF;
		prog = 1'b0;
		busy = BUSY_READS;
		pend = CMD_READ;
		cmd = CMD_READ;
	endtask : erase
	initial begin
		for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hFF;
		{cmd, pend, pd, last, prog, tog, busy} = '0;
	end
	always @(posedge wr_act) la = addr_in;
	always @(negedge wr_act) if (vpp_in && busy == 0) begin
		if (pend == CMD_PROGRAM) begin
			mem[la] = dq_in;
			pd = dq_in;
			prog = 1'b1;
			busy = BUSY_READS;
			pend = CMD_READ;
		end else if (pend == CMD_CHIP_ERASE && dq_in == CMD_CHIP_ERASE)
			erase('0, 1<<ADDR_W);
		else if (pend == CMD_BLOCK_SETUP && dq_in == CMD_BLOCK_CONFIRM)
			erase({la[17:12], 12'h000}, 4096);
		else if (pend == CMD_ABORT && dq_in == CMD_ABORT) begin
			pend = CMD_READ;
			cmd = CMD_READ;
		end else begin
			pend = dq_in;
			cmd = dq_in;
		end
	end
	always @(posedge oe_n_in) begin
		last = val;
		if (busy > 0) begin
			busy--;
			tog = ~tog;
		end
	end
	assign val = busy > 0 ? (prog ? {~pd[7], tog, pd[5:0]}
		: {1'b0, tog, 6'h00})
		: (vpp_in && cmd == CMD_IDENT) ? (addr_in[0] ? DEV_CODE : MFR_CODE)
		: mem[addr_in];
	// Released bus shows the inverse of the last value, never a stale copy
	assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~last;
endmodule : fcs_flash_model

// file: fcs_host.sv
// Host controller that drives a byte-wide flash through its command pins
module fcs_host
	import fcs_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic REQ_VALID_IN,
	input wire logic [2:0] REQ_OP_IN,
	input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
	input wire logic [DATA_W-1:0] REQ_DATA_IN,
	input wire logic REQ_LAST_IN,
	input wire logic VPP_HIGH_IN,
	input wire logic [DATA_W-1:0] FLASH_DQ_IN,
	output logic REQ_READY_OUT,
	output logic RSP_VALID_OUT,
	output logic [DATA_W-1:0] RSP_DATA_OUT,
	output logic RSP_ERROR_OUT,
	output logic BUSY_OUT,
	output logic [ADDR_W-1:0] FLASH_ADDR_OUT,
	output logic [DATA_W-1:0] FLASH_DQ_OUT,
	output logic FLASH_DQ_OE_N_OUT,
	output logic FLASH_CE_N_OUT,
	output logic FLASH_OE_N_OUT,
	output logic FLASH_WE_N_OUT
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_WR_LOW = 4'b0001,
		ST_WR_HIGH = 4'b0010,
		ST_RD_LOW = 4'b0011,
		ST_RD_DONE = 4'b0100,
		ST_BLK_WAIT = 4'b0101,
		ST_POLL = 4'b0110,
		ST_POLL_EVAL = 4'b0111,
		ST_DONE = 4'b1000
	} fcs_state_t;

	fcs_state_t state_reg, state_next;
	logic [2:0] op_reg, op_next;
	logic [1:0] step_reg, step_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [DATA_W-1:0] dq_reg, dq_next;
	logic dq_oe_n_reg, dq_oe_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic ce_n_reg, ce_n_next;
	logic ready_reg, ready_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;
	logic rsp_err_reg, rsp_err_next;
	logic busy_reg, busy_next;
	logic have_prev_reg, have_prev_next;
	logic [DATA_W-1:0] prev_reg, prev_next;
	logic [BLK_AW-1:0] blk_cnt_reg, blk_cnt_next;
	logic blk_wr;
	logic [ADDR_W-1:0] blk_rd_data;

	// Loaded block list is stored here, but its read data reaches no port the caller can see
	fcs_blk_mem u_blk_mem (
		.clk_in(CLOCK_IN),
		.wr_en_in(blk_wr),
		.wr_addr_in(blk_cnt_next),
		.wr_data_in(REQ_ADDR_IN),
		.rd_addr_in(blk_cnt_reg),
		.rd_data_out(blk_rd_data)
	);

	// Command byte for the current step of the current operation
	function automatic logic [DATA_W-1:0] step_byte(input logic [2:0] op,
		input logic [1:0] step, input logic [DATA_W-1:0] d);
		unique case (op)
			OP_IDENT: step_byte = CMD_IDENT;
			OP_CHIP_ERASE: step_byte = CMD_CHIP_ERASE;
			OP_BLOCK_ERASE: step_byte = (step == 2'd0) ? CMD_BLOCK_SETUP
				: CMD_BLOCK_CONFIRM;
			OP_PROGRAM: step_byte = (step == 2'd0) ? CMD_PROGRAM : d;
			OP_ABORT: step_byte = CMD_ABORT;
			default: step_byte = CMD_READ;
		endcase
	endfunction : step_byte

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		dq_next = dq_reg;
		dq_oe_n_next = dq_oe_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		ce_n_next = ce_n_reg;
		ready_next = 1'b0;
		rsp_valid_next = 1'b0;
		rsp_data_next = rsp_data_reg;
		rsp_err_next = rsp_err_reg;
		busy_next = busy_reg;
		have_prev_next = have_prev_reg;
		prev_next = prev_reg;
		blk_cnt_next = blk_cnt_reg;
		blk_wr = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				ready_next = 1'b1;
				if (REQ_VALID_IN && ready_reg) begin
					ready_next = 1'b0;
					op_next = REQ_OP_IN;
					addr_next = REQ_ADDR_IN;
					wdata_next = REQ_DATA_IN;
					step_next = 2'd0;
					cnt_next = '0;
					blk_cnt_next = '0;
					rsp_err_next = 1'b0;
					if (!VPP_HIGH_IN && REQ_OP_IN != OP_READ) begin
						// Device would ignore it anyway; report at once
						rsp_valid_next = 1'b1;
						rsp_err_next = 1'b1;
						ready_next = 1'b1;
					end else if (REQ_OP_IN == OP_READ && !VPP_HIGH_IN) begin
						state_next = ST_RD_LOW;
						ce_n_next = 1'b0;
						oe_n_next = 1'b0;
					end else begin
						state_next = ST_WR_LOW;
						ce_n_next = 1'b0;
						we_n_next = 1'b0;
						dq_oe_n_next = 1'b0;
						dq_next = step_byte(REQ_OP_IN, 2'd0, REQ_DATA_IN);
						if (REQ_OP_IN == OP_BLOCK_ERASE) begin
							blk_wr = 1'b1;
						end
					end
				end
			end
			ST_WR_LOW: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(STROBE_CYC - 1)) begin
					cnt_next = '0;
					we_n_next = 1'b1;
					ce_n_next = 1'b1;
					state_next = ST_WR_HIGH;
				end
			end
			ST_WR_HIGH: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(STROBE_CYC - 1)) begin
					cnt_next = '0;
					dq_oe_n_next = 1'b1;
					step_next = step_reg + 1'b1;
					if (op_reg != OP_READ && op_reg != OP_IDENT
						&& step_reg == 2'd0) begin
						// Second cycle; address fixed before strobe falls
						state_next = ST_WR_LOW;
						ce_n_next = 1'b0;
						we_n_next = 1'b0;
						dq_oe_n_next = 1'b0;
						dq_next = step_byte(op_reg, 2'd1, wdata_reg);
					end else if (op_reg == OP_BLOCK_ERASE) begin
						state_next = ST_BLK_WAIT;
						ready_next = 1'b1;
					end else if (op_reg == OP_IDENT || op_reg == OP_READ) begin
						state_next = ST_RD_LOW;
						ce_n_next = 1'b0;
						oe_n_next = 1'b0;
					end else if (op_reg == OP_ABORT) begin
						state_next = ST_DONE;
					end else begin
						busy_next = 1'b1;
						have_prev_next = 1'b0;
						state_next = ST_POLL;
					end
				end
			end
			ST_BLK_WAIT: begin
				ready_next = 1'b1;
				cnt_next = cnt_reg + 1'b1;
				if (REQ_VALID_IN && ready_reg && REQ_LAST_IN == 1'b0
					&& blk_cnt_reg != BLK_AW'(BLK_DEPTH - 1)) begin
					// Margin of a few cycles kept under the window
					ready_next = 1'b0;
					addr_next = REQ_ADDR_IN;
					blk_cnt_next = blk_cnt_reg + 1'b1;
					blk_wr = 1'b1;
					cnt_next = '0;
					ce_n_next = 1'b0;
					we_n_next = 1'b0;
					dq_oe_n_next = 1'b0;
					dq_next = CMD_BLOCK_CONFIRM;
					step_next = 2'd1;
					state_next = ST_WR_LOW;
				end else if (cnt_reg >= CNT_W'(LOAD_WINDOW_CYC - LOAD_MARGIN_CYC)
					|| (REQ_VALID_IN && ready_reg)) begin
					// Let the window lapse so the device starts erasing
					ready_next = 1'b0;
					busy_next = 1'b1;
					have_prev_next = 1'b0;
					state_next = ST_POLL;
				end
			end
			ST_RD_LOW: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(ACCESS_CYC)) begin
					cnt_next = '0;
					rsp_data_next = FLASH_DQ_IN;
					ce_n_next = 1'b1;
					oe_n_next = 1'b1;
					state_next = ST_RD_DONE;
				end
			end
			ST_RD_DONE: begin
				rsp_valid_next = 1'b1;
				ready_next = 1'b1;
				state_next = ST_IDLE;
			end
			ST_POLL: begin
				ce_n_next = 1'b0;
				oe_n_next = 1'b0;
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(ACCESS_CYC)) begin
					cnt_next = '0;
					have_prev_next = 1'b1;
					ce_n_next = 1'b1;
					oe_n_next = 1'b1;
					state_next = have_prev_reg ? ST_POLL_EVAL : ST_POLL;
					// Older reads move down prev and dq in the evaluation step
					if (have_prev_reg) begin
						rsp_data_next = FLASH_DQ_IN;
					end else begin
						prev_next = FLASH_DQ_IN;
					end
				end
			end
			ST_POLL_EVAL: begin
				state_next = ST_POLL;
				// Toggle still moving means the algorithm is running
				if (rsp_data_reg[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]
					&& dq_reg[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]) begin
					if (op_reg == OP_PROGRAM) begin
						rsp_err_next = rsp_data_reg[POLL_BIT:TOGGLE_BIT]
							!= wdata_reg[POLL_BIT:TOGGLE_BIT];
					end else begin
						rsp_err_next = !rsp_data_reg[POLL_BIT];
					end
					state_next = ST_DONE;
				end
				// Data bus is released while polling, so dq keeps the oldest read
				prev_next = rsp_data_reg;
				dq_next = prev_reg;
			end
			ST_DONE: begin
				busy_next = 1'b0;
				rsp_valid_next = 1'b1;
				ready_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_READ;
			step_reg <= '0;
			cnt_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			dq_reg <= '0;
			dq_oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			ce_n_reg <= 1'b1;
			ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= '0;
			rsp_err_reg <= 1'b0;
			busy_reg <= 1'b0;
			have_prev_reg <= 1'b0;
			prev_reg <= '0;
			blk_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			dq_reg <= dq_next;
			dq_oe_n_reg <= dq_oe_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			ce_n_reg <= ce_n_next;
			ready_reg <= ready_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
			rsp_err_reg <= rsp_err_next;
			busy_reg <= busy_next;
			have_prev_reg <= have_prev_next;
			prev_reg <= prev_next;
			blk_cnt_reg <= blk_cnt_next;
		end
	end

	assign REQ_READY_OUT = ready_reg;
	assign RSP_VALID_OUT = rsp_valid_reg;
	assign RSP_DATA_OUT = rsp_data_reg;
	assign RSP_ERROR_OUT = rsp_err_reg;
	assign BUSY_OUT = busy_reg;
	assign FLASH_ADDR_OUT = addr_reg;
	assign FLASH_DQ_OUT = dq_reg;
	assign FLASH_DQ_OE_N_OUT = dq_oe_n_reg;
	assign FLASH_CE_N_OUT = ce_n_reg;
	assign FLASH_OE_N_OUT = oe_n_reg;
	assign FLASH_WE_N_OUT = we_n_reg;
endmodule : fcs_host

// file: fcs_host_properties.sv
// Checker: pin and handshake rules of the flash host
module fcs_host_properties
	import fcs_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic REQ_VALID_IN,
	input wire logic [2:0] REQ_OP_IN,
	input wire logic VPP_HIGH_IN,
	input wire logic REQ_READY_OUT,
	input wire logic RSP_VALID_OUT,
	input wire logic RSP_ERROR_OUT,
	input wire logic BUSY_OUT,
	input wire logic [ADDR_W-1:0] FLASH_ADDR_OUT,
	input wire logic [DATA_W-1:0] FLASH_DQ_OUT,
	input wire logic FLASH_DQ_OE_N_OUT,
	input wire logic FLASH_CE_N_OUT,
	input wire logic FLASH_OE_N_OUT,
	input wire logic FLASH_WE_N_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence s_take;
		REQ_VALID_IN && REQ_READY_OUT;
	endsequence
	sequence s_we_pulse;
		!FLASH_WE_N_OUT [*2] ##1 FLASH_WE_N_OUT;
	endsequence
	sequence s_cmd(logic [7:0] c);
		!FLASH_WE_N_OUT && FLASH_DQ_OUT == c;
	endsequence
	AST_WE_NEEDS_VPP: assert property (!FLASH_WE_N_OUT |-> VPP_HIGH_IN)
		else $error("write strobe with low supply");
	AST_WE_WITH_CE: assert property (!FLASH_WE_N_OUT |-> !FLASH_CE_N_OUT)
		else $error("write strobe without chip select");
	AST_WE_DRIVES: assert property (!FLASH_WE_N_OUT |-> !FLASH_DQ_OE_N_OUT)
		else $error("write strobe with data bus released");
	AST_NO_CONTENTION: assert property (
		!FLASH_OE_N_OUT |-> FLASH_DQ_OE_N_OUT && FLASH_WE_N_OUT)
		else $error("read while driving bus");
	AST_WE_PULSE: assert property ($fell(FLASH_WE_N_OUT) |-> s_we_pulse)
		else $error("write strobe width wrong");
	AST_WR_STABLE: assert property (
		!FLASH_WE_N_OUT && !$past(FLASH_WE_N_OUT)
		|-> $stable(FLASH_DQ_OUT) && $stable(FLASH_ADDR_OUT))
		else $error("write data or address moved");
	AST_RSP_PULSE: assert property (RSP_VALID_OUT |=> !RSP_VALID_OUT)
		else $error("response longer than one cycle");
	AST_BUSY_NO_TAKE: assert property (BUSY_OUT |-> !REQ_READY_OUT)
		else $error("ready while device busy");
	AST_REFUSE: assert property (
		s_take ##0 (!VPP_HIGH_IN && REQ_OP_IN != OP_READ)
		|-> ##[1:2] (RSP_VALID_OUT && RSP_ERROR_OUT))
		else $error("low supply request not refused");
	AST_READ_CMD: assert property (
		s_take ##0 (VPP_HIGH_IN && REQ_OP_IN == OP_READ)
		|-> ##[1:2] s_cmd(CMD_READ)) else $error("read command missing");
	AST_IDENT_CMD: assert property (
		s_take ##0 (VPP_HIGH_IN && REQ_OP_IN == OP_IDENT)
		|-> ##[1:2] s_cmd(CMD_IDENT)) else $error("ident command missing");
endmodule : fcs_host_properties

// file: fcs_host_tb.sv
// Testbench: host controller against the flash model
module fcs_host_tb;
	import fcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, valid, last, vpp, err;
	logic [2:0] op;
	logic [17:0] addr, fa;
	logic [7:0] data, fdo, fdi, rsp_d, got;
	logic ready, rsp_v, rsp_e, busy, dq_oe_n, ce_n, oe_n, we_n;
	int bad_count, samples_checked;
	fcs_host uut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .REQ_VALID_IN(valid),
		.REQ_OP_IN(op), .REQ_ADDR_IN(addr), .REQ_DATA_IN(data),
		.REQ_LAST_IN(last), .VPP_HIGH_IN(vpp), .FLASH_DQ_IN(fdi),
		.REQ_READY_OUT(ready), .RSP_VALID_OUT(rsp_v), .RSP_DATA_OUT(rsp_d),
		.RSP_ERROR_OUT(rsp_e), .BUSY_OUT(busy), .FLASH_ADDR_OUT(fa),
		.FLASH_DQ_OUT(fdo), .FLASH_DQ_OE_N_OUT(dq_oe_n),
		.FLASH_CE_N_OUT(ce_n), .FLASH_OE_N_OUT(oe_n), .FLASH_WE_N_OUT(we_n));
	fcs_flash_model dev (.vpp_in(vpp), .ce_n_in(ce_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .addr_in(fa), .dq_in(fdo), .dq_out(fdi));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// One request, held until taken, then wait for its response
	task automatic req(input logic [2:0] o, input logic [17:0] a,
		input logic [7:0] d);
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		addr <= a;
		data <= d;
		@(posedge clk);
		while (ready !== 1'b1) @(posedge clk);
		valid <= 1'b0;
		@(posedge clk);
		while (rsp_v !== 1'b1) @(posedge clk);
		got = rsp_d;
		err = rsp_e;
	endtask : req
	task automatic t_lowvpp();
		@(posedge clk) vpp <= 1'b0;
		req(OP_READ, 18'h0_0005, 8'h00);
		check(got, 8'hFF);
		req(OP_PROGRAM, 18'h0_0005, 8'h00);
		check({7'h00, err}, 8'h01);
		req(OP_CHIP_ERASE, 18'h0_0000, 8'h00);
		check({7'h00, err}, 8'h01);
		@(posedge clk) vpp <= 1'b1;
		$display("test low supply done");
	endtask : t_lowvpp
	task automatic t_ident();
		req(OP_IDENT, IDENT_MFR_ADDR, 8'h00);
		check(got, dev.MFR_CODE);
		req(OP_IDENT, IDENT_DEV_ADDR, 8'h00);
		check(got, dev.DEV_CODE);
		req(OP_READ, 18'h0_0001, 8'h00);
		check(got, 8'hFF);
		$display("test ident done");
	endtask : t_ident
	task automatic t_prog();
		logic [17:0] a [3] = '{18'h0_0005, 18'h0_1000, 18'h0_5000};
		logic [7:0] d [3] = '{8'h3A, 8'hC5, 8'h81};
		for (int i = 0; i < 3; i++) begin
			req(OP_PROGRAM, a[i], d[i]);
			check({7'h00, err}, 8'h00);
			req(OP_READ, a[i], 8'h00);
			check(got, d[i]);
		end
		$display("test program done");
	endtask : t_prog
	task automatic t_block();
		req(OP_BLOCK_ERASE, 18'h0_1234, 8'h00);
		check({7'h00, err}, 8'h00);
		req(OP_READ, 18'h0_1000, 8'h00);
		check(got, 8'hFF);
		req(OP_READ, 18'h0_5000, 8'h00);
		check(got, 8'h81);
		$display("test block erase done");
	endtask : t_block
	task automatic t_chip();
		req(OP_CHIP_ERASE, 18'h0_0000, 8'h00);
		check({7'h00, err}, 8'h00);
		req(OP_READ, 18'h0_5000, 8'h00);
		check(got, 8'hFF);
		$display("test chip erase done");
	endtask : t_chip
	task automatic t_abort();
		req(OP_ABORT, 18'h0_0000, 8'h00);
		check({7'h00, err}, 8'h00);
		req(OP_PROGRAM, 18'h0_0007, 8'h66);
		check({7'h00, err}, 8'h00);
		req(OP_READ, 18'h0_0007, 8'h00);
		check(got, 8'h66);
		$display("test abort done");
	endtask : t_abort
	initial begin
		{rst, valid, last, vpp, op, addr, data} = '0;
		rst = 1'b1;
		bad_count = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_lowvpp();
		t_ident();
		t_prog();
		t_block();
		t_chip();
		t_abort();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule : fcs_host_tb
bind fcs_host fcs_host_properties chk (.CLOCK_IN(CLOCK_IN),
	.SYS_RST_IN(SYS_RST_IN), .REQ_VALID_IN(REQ_VALID_IN),
	.REQ_OP_IN(REQ_OP_IN), .VPP_HIGH_IN(VPP_HIGH_IN),
	.REQ_READY_OUT(REQ_READY_OUT), .RSP_VALID_OUT(RSP_VALID_OUT),
	.RSP_ERROR_OUT(RSP_ERROR_OUT), .BUSY_OUT(BUSY_OUT),
	.FLASH_ADDR_OUT(FLASH_ADDR_OUT), .FLASH_DQ_OUT(FLASH_DQ_OUT),
	.FLASH_DQ_OE_N_OUT(FLASH_DQ_OE_N_OUT), .FLASH_CE_N_OUT(FLASH_CE_N_OUT),
	.FLASH_OE_N_OUT(FLASH_OE_N_OUT), .FLASH_WE_N_OUT(FLASH_WE_N_OUT));

// file: fcs_pkg.sv
// Package: command bytes, pin widths and timing constants for the flash host
package fcs_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
	localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
	localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ABORT = 8'hFF;
	localparam logic [ADDR_W-1:0] IDENT_MFR_ADDR = 18'h0_0000;
	localparam logic [ADDR_W-1:0] IDENT_DEV_ADDR = 18'h0_0001;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	// Bus phase lengths in clock cycles at 25 MHz
	localparam int CLK_PERIOD_NS = 40;
	localparam int ACCESS_NS = 120;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = 2;
	// Block load window, longest time rounded down
	localparam int LOAD_WINDOW_NS = 30000;
	localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_NS / CLK_PERIOD_NS;
	// Cycles kept in hand before the window so the next strobe still counts
	localparam int LOAD_MARGIN_CYC = 8;
	localparam int CNT_W = 10;
	// Operation codes on the user request port
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_IDENT = 3'h1;
	localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
	localparam logic [2:0] OP_BLOCK_ERASE = 3'h3;
	localparam logic [2:0] OP_PROGRAM = 3'h4;
	localparam logic [2:0] OP_ABORT = 3'h5;
	localparam int BLK_DEPTH = 32;
	localparam int BLK_AW = 5;
endpackage : fcs_pkg
